// file: lcts_chan_track.sv
`timescale 1ns/1ps
module lcts_chan_track #(
    parameter int SETTLE = 500
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic on_i,
    input wire logic dis_i,
    output logic valid_o,
    output logic off_edge_o
);
    logic [$clog2(SETTLE+1)-1:0] cnt_q;
    logic on_q;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cnt_q <= '0;
        end else if (!on_i || dis_i) begin
            cnt_q <= '0;
        end else if (cnt_q != SETTLE[$clog2(SETTLE+1)-1:0]) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            on_q <= 1'b0;
        end else begin
            on_q <= on_i;
        end
    end

    assign valid_o = on_i && !dis_i && (cnt_q == SETTLE[$clog2(SETTLE+1)-1:0]);
    // Switch-off instant counts only if a settled reading existed
    assign off_edge_o = on_q && !on_i && (cnt_q == SETTLE[$clog2(SETTLE+1)-1:0]);
endmodule // lcts_chan_track

// file: lcts_host_model.sv
`timescale 1ns/1ps
module lcts_host_model (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic sense_valid_n_i,
    input wire logic sense_offset_pos_i,
    output logic [1:0] pol_seen_o
);
    // Host marks each polarity for which it has seen a settled reading
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pol_seen_o <= 2'h0;
        end else if (!sense_valid_n_i) begin
            pol_seen_o[sense_offset_pos_i] <= 1'b1;
        end
    end
endmodule // lcts_host_model

// file: lcts_pkg.sv
package lcts_pkg;
    localparam int CLK_HZ = 50_000_000;
    localparam int SETTLE_NS = 10_000;
    localparam int SETTLE_CYCLES = (SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

    localparam logic [7:0] GENERAL_CONFIG_OFF = 8'h00;
    localparam logic [7:0] OVERCURRENT_CONFIG_OFF = 8'h04;
    localparam logic [7:0] RETRY_CONFIG_OFF = 8'h08;
    localparam logic [7:0] FAULT_REPORT_OFF = 8'h0c;
    localparam logic [7:0] STATUS_REPORT_OFF = 8'h10;

    localparam int SEL_LO_POS = 0;
    localparam int SEL_HI_POS = 1;
    localparam int HOLD_MODE_POS = 2;
    localparam int RATIO_POS = 0;
    localparam int OFFSET_POL_POS = 8;
    localparam int PREWARN_POS = 8;
    localparam int STATE_POS = 0;

    localparam logic [2:0] GENERAL_CONFIG_RST = 3'h0;
    localparam logic [1:0] RATIO_RST = 2'h0;
    localparam logic [1:0] OFFSET_POL_RST = 2'h0;

    typedef enum logic [1:0] {
        SRC_NONE,
        SRC_CH0,
        SRC_CH1,
        SRC_TEMP
    } lcts_src_type;
endpackage

// file: lcts_sense_ctrl.sv
`timescale 1ns/1ps
module lcts_sense_ctrl (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] chan_on_i,
    input wire logic [1:0] oc_window_i,
    input wire logic normal_mode_i,
    input wire logic [1:0] above_lowest_oc_i,
    input wire logic [1:0] out_above_half_i,
    input wire logic temp_hot_i,
    output lcts_pkg::lcts_src_type sense_source_o,
    output logic sense_enable_o,
    output logic sense_hold_o,
    output logic sense_discharge_o,
    output logic sense_offset_pos_o,
    output logic [1:0] sense_ratio_low_o,
    output logic [1:0] oc_threshold_low_o,
    output logic sense_valid_n_o,
    output logic temp_prewarning_flag_o
);
    import lcts_pkg::*;

    logic [2:0] general_config_q;
    logic [1:0] ratio_q;
    logic [1:0] offset_pol_q;
    logic temp_prewarning_flag_q;
    logic [31:0] prdata_q;
    logic [4:0] sync1_q, sync2_q;
    logic [1:0] over_oc_s, out_state_s;
    logic temp_hot_s;
    logic [1:0] valid_w, off_edge_w;
    logic [1:0] sel_prev_q;
    logic hold_q, hold_pol_q, sense_en_q, discharge_q, sync_n_q;
    lcts_src_type src_q;
    logic hold_d, pol_d, en_d, dis_d, sync_d;
    lcts_src_type src_d;
    logic [1:0] sel;
    logic th_mode, cur_sel, ch, sel_changed, ch_dis, wr_en, rd_acc, fault_rd;

    // Pins from the analog side cross through two flops
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sync1_q <= 5'h00;
            sync2_q <= 5'h00;
        end else begin
            sync1_q <= {temp_hot_i, out_above_half_i, above_lowest_oc_i};
            sync2_q <= sync1_q;
        end
    end
    assign over_oc_s = sync2_q[1:0];
    assign out_state_s = sync2_q[3:2];
    assign temp_hot_s = sync2_q[4];

    // APB: one access cycle, no wait states
    assign pready = penable;
    assign wr_en = psel && penable && pwrite;
    assign rd_acc = psel && penable && !pwrite;
    assign fault_rd = rd_acc && (paddr == FAULT_REPORT_OFF);
    assign pslverr = psel && penable && !(paddr == GENERAL_CONFIG_OFF || paddr == OVERCURRENT_CONFIG_OFF
        || paddr == RETRY_CONFIG_OFF || paddr == FAULT_REPORT_OFF || paddr == STATUS_REPORT_OFF);
    assign prdata = prdata_q;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            general_config_q <= GENERAL_CONFIG_RST;
            ratio_q <= RATIO_RST;
            offset_pol_q <= OFFSET_POL_RST;
        end else if (wr_en) begin
            case (paddr)
                GENERAL_CONFIG_OFF: general_config_q <= pwdata[2:0];
                OVERCURRENT_CONFIG_OFF: ratio_q <= pwdata[RATIO_POS +: 2];
                RETRY_CONFIG_OFF: offset_pol_q <= pwdata[OFFSET_POL_POS +: 2];
                default: ;
            endcase
        end
    end

    // Read data is captured in the setup cycle so it stands registered
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            prdata_q <= 32'h0;
        end else if (psel && !penable) begin
            prdata_q <= 32'h0;
            case (paddr)
                GENERAL_CONFIG_OFF: prdata_q[2:0] <= general_config_q;
                OVERCURRENT_CONFIG_OFF: prdata_q[RATIO_POS +: 2] <= ratio_q;
                RETRY_CONFIG_OFF: prdata_q[OFFSET_POL_POS +: 2] <= offset_pol_q;
                FAULT_REPORT_OFF: prdata_q[PREWARN_POS] <= temp_prewarning_flag_q;
                STATUS_REPORT_OFF: prdata_q[STATE_POS +: 2] <= out_state_s;
                default: ;
            endcase
        end
    end

    // Set wins: a hot die during the read keeps the flag
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            temp_prewarning_flag_q <= 1'b0;
        end else if (normal_mode_i && temp_hot_s) begin
            temp_prewarning_flag_q <= 1'b1;
        end else if (fault_rd && !temp_hot_s) begin
            temp_prewarning_flag_q <= 1'b0;
        end
    end
    assign temp_prewarning_flag_o = temp_prewarning_flag_q;

    // Low ratio also drops the overcurrent profile
    assign sense_ratio_low_o = ratio_q;
    assign oc_threshold_low_o = ratio_q;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_track
            lcts_chan_track #(
                .SETTLE(SETTLE_CYCLES)
            ) u_track (
                .clk_i(clk_i),
                .rst_n_i(rst_n_i),
                .on_i(chan_on_i[gi]),
                .dis_i(oc_window_i[gi] || over_oc_s[gi]),
                .valid_o(valid_w[gi]),
                .off_edge_o(off_edge_w[gi])
            );
        end
    endgenerate

    assign sel = {general_config_q[SEL_HI_POS], general_config_q[SEL_LO_POS]};
    assign th_mode = general_config_q[HOLD_MODE_POS];
    assign cur_sel = sel[0] ^ sel[1];
    assign ch = sel[1];
    assign sel_changed = sel != sel_prev_q;
    assign ch_dis = oc_window_i[ch] || over_oc_s[ch];

    always_comb begin
        src_d = SRC_NONE;
        en_d = 1'b0;
        hold_d = 1'b0;
        pol_d = hold_pol_q;
        dis_d = 1'b0;
        sync_d = 1'b1;
        case (sel)
            2'b01: src_d = SRC_CH0;
            2'b10: src_d = SRC_CH1;
            2'b11: src_d = SRC_TEMP;
            default: src_d = SRC_NONE;
        endcase
        if (sel == 2'b11) begin
            en_d = 1'b1;
        end else if (cur_sel) begin
            if (sel_changed) begin
                dis_d = th_mode;
            end else if (ch_dis) begin
                sync_d = 1'b1;
            end else if (chan_on_i[ch]) begin
                pol_d = offset_pol_q[ch];
                en_d = valid_w[ch];
                sync_d = !valid_w[ch];
            end else if (th_mode && (off_edge_w[ch] || hold_q)) begin
                // Polarity stays as tracked while on
                hold_d = 1'b1;
                en_d = 1'b1;
                sync_d = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            src_q <= SRC_NONE;
            sense_en_q <= 1'b0;
            hold_q <= 1'b0;
            hold_pol_q <= 1'b0;
            discharge_q <= 1'b0;
            sync_n_q <= 1'b1;
            sel_prev_q <= 2'h0;
        end else begin
            src_q <= src_d;
            sense_en_q <= en_d;
            hold_q <= hold_d;
            hold_pol_q <= pol_d;
            discharge_q <= dis_d;
            sync_n_q <= sync_d;
            sel_prev_q <= sel;
        end
    end

    assign sense_source_o = src_q;
    assign sense_enable_o = sense_en_q;
    assign sense_hold_o = hold_q;
    assign sense_discharge_o = discharge_q;
    assign sense_offset_pos_o = hold_pol_q;
    assign sense_valid_n_o = sync_n_q;

    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    temp_route_a: assert property (sel == 2'b11 |=> sense_source_o == SRC_TEMP && sense_enable_o)
        else $error("temperature not routed");
    oc_window_a: assert property (cur_sel && !sel_changed && ch_dis |=> sense_valid_n_o && !sense_enable_o)
        else $error("sensing active in overcurrent window");
    mode_reset_a: assert property (@(posedge clk_i) disable iff (1'b0) !rst_n_i |=> !general_config_q[HOLD_MODE_POS])
        else $error("hold mode not cleared by reset");
    sync_low_a: assert property (cur_sel && !sel_changed && valid_w[ch] |=> !sense_valid_n_o && sense_enable_o)
        else $error("sync not low when sense valid");
    sync_off_a: assert property (cur_sel && !th_mode && !chan_on_i[ch] |=> !sense_enable_o && sense_valid_n_o)
        else $error("current shown after turn-off");
    hold_take_a: assert property (cur_sel && th_mode && !sel_changed && !ch_dis && off_edge_w[ch]
        |=> sense_hold_o && sense_enable_o && sense_valid_n_o)
        else $error("no hold at switch-off");
    hold_pol_a: assert property (sense_hold_o && $past(sense_hold_o) |-> $stable(sense_offset_pos_o))
        else $error("held polarity changed");
    change_drop_a: assert property (th_mode && sel_changed && cur_sel |=> !sense_hold_o && sense_discharge_o)
        else $error("held value kept across channel change");
    warn_set_a: assert property (normal_mode_i && temp_hot_s |=> temp_prewarning_flag_o)
        else $error("prewarning not set");
    warn_keep_a: assert property (temp_prewarning_flag_o && !fault_rd |=> temp_prewarning_flag_o)
        else $error("prewarning cleared without read");
    warn_read_a: assert property (fault_rd && !temp_hot_s && !(normal_mode_i && temp_hot_s)
        ##1 !(normal_mode_i && temp_hot_s) |-> !temp_prewarning_flag_o)
        else $error("prewarning not cleared by read");
    warn_mode_a: assert property (!normal_mode_i && !temp_prewarning_flag_o |=> !temp_prewarning_flag_o)
        else $error("prewarning set outside normal mode");
    src_ch0_a: assert property (sel == 2'b01 |=> sense_source_o == SRC_CH0)
        else $error("channel zero not routed");
    src_ch1_a: assert property (sel == 2'b10 |=> sense_source_o == SRC_CH1)
        else $error("channel one not routed");
    src_off_a: assert property (sel == 2'b00 |=> sense_source_o == SRC_NONE && !sense_enable_o)
        else $error("sense output not disabled");
    hold_keep_a: assert property (cur_sel && th_mode && !sel_changed && !ch_dis && !chan_on_i[ch] && sense_hold_o
        |=> sense_hold_o && sense_enable_o && sense_valid_n_o)
        else $error("held value dropped while off");
    above_oc_a: assert property (cur_sel && !sel_changed && over_oc_s[ch] |=> !sense_enable_o)
        else $error("sensing above lowest overcurrent level");
    status_read_a: assert property (psel && !penable && paddr == STATUS_REPORT_OFF
        |=> prdata[1:0] == $past(out_state_s))
        else $error("status bits not captured");
endmodule // lcts_sense_ctrl

// file: lcts_sense_ctrl_tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin failures++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
module lcts_sense_ctrl_tb_top;
    import lcts_pkg::*;
    logic clk_i = 0, rst_n_i = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd_data;
    logic pready, pslverr, rd_err, normal_mode_i = 1, temp_hot_i = 0;
    logic [1:0] chan_on_i = 0, oc_window_i = 0, above_lowest_oc_i = 0, out_above_half_i = 0;
    logic [1:0] sense_ratio_low_o, oc_threshold_low_o, pol_seen;
    lcts_src_type sense_source_o;
    logic sense_enable_o, sense_hold_o, sense_discharge_o, sense_offset_pos_o, sense_valid_n_o, temp_prewarning_flag_o;
    int failures = 0, num_checks = 0, n;
    lcts_sense_ctrl u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .chan_on_i(chan_on_i), .oc_window_i(oc_window_i), .normal_mode_i(normal_mode_i),
        .above_lowest_oc_i(above_lowest_oc_i), .out_above_half_i(out_above_half_i), .temp_hot_i(temp_hot_i),
        .sense_source_o(sense_source_o), .sense_enable_o(sense_enable_o), .sense_hold_o(sense_hold_o),
        .sense_discharge_o(sense_discharge_o), .sense_offset_pos_o(sense_offset_pos_o),
        .sense_ratio_low_o(sense_ratio_low_o), .oc_threshold_low_o(oc_threshold_low_o),
        .sense_valid_n_o(sense_valid_n_o), .temp_prewarning_flag_o(temp_prewarning_flag_o));
    lcts_host_model u_host (.clk_i(clk_i), .rst_n_i(rst_n_i), .sense_valid_n_i(sense_valid_n_o),
        .sense_offset_pos_i(sense_offset_pos_o), .pol_seen_o(pol_seen));
    initial begin
        forever #10 clk_i = ~clk_i;
    end
    task print_verdict();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk_i);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk_i);
        penable <= 1;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            failures++;
            print_verdict();
        end
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task tick(input int c);
        repeat (c) @(posedge clk_i);
        #1;
    endtask
    // Settling runs hundreds of cycles, so the bound leaves margin
    task wait_valid();
        n = 0;
        while (sense_valid_n_o !== 1'b0 && n < 700) begin
            tick(1);
            n++;
        end
        if (n >= 700) begin
            failures++;
            print_verdict();
        end
    endtask
    initial begin
        repeat (5) @(posedge clk_i);
        rst_n_i <= 1;
        tick(1);
        `CHK("valid_n", 1'b1, sense_valid_n_o)
        apb(0, GENERAL_CONFIG_OFF, 0); `CHK("gcr", 32'h0, rd_data)
        for (int i = 0; i < 4; i++) begin
            apb(1, GENERAL_CONFIG_OFF, i); tick(2); `CHK("src", lcts_src_type'(i), sense_source_o)
        end
        apb(1, GENERAL_CONFIG_OFF, 1);
        @(posedge clk_i) chan_on_i <= 2'b01;
        wait_valid(); `CHK("enable", 1'b1, sense_enable_o)
        @(posedge clk_i) oc_window_i <= 2'b01;
        tick(2); `CHK("oc valid_n", 1'b1, sense_valid_n_o)
        `CHK("oc enable", 1'b0, sense_enable_o)
        @(posedge clk_i) oc_window_i <= 2'b00;
        wait_valid();
        @(posedge clk_i) above_lowest_oc_i <= 2'b01;
        tick(4); `CHK("above oc", 1'b0, sense_enable_o)
        @(posedge clk_i) above_lowest_oc_i <= 2'b00;
        @(posedge clk_i) chan_on_i <= 2'b00;
        tick(4); `CHK("off enable", 1'b0, sense_enable_o)
        apb(1, RETRY_CONFIG_OFF, 32'h100);
        apb(1, GENERAL_CONFIG_OFF, 5);
        @(posedge clk_i) chan_on_i <= 2'b01;
        wait_valid(); `CHK("pol", 1'b1, sense_offset_pos_o)
        @(posedge clk_i) chan_on_i <= 2'b00;
        tick(2); `CHK("hold", 1'b1, sense_hold_o)
        `CHK("held en", 1'b1, sense_enable_o)
        `CHK("th valid_n", 1'b1, sense_valid_n_o)
        apb(1, GENERAL_CONFIG_OFF, 6);
        n = 0;
        repeat (4) begin
            tick(1);
            n += (sense_discharge_o === 1'b1);
        end
        `CHK("discharge", 1, n)
        `CHK("hold drop", 1'b0, sense_hold_o)
        `CHK("host pol", 2'b11, pol_seen)
        apb(1, OVERCURRENT_CONFIG_OFF, 2); tick(2); `CHK("ratio", 2'b10, sense_ratio_low_o)
        `CHK("oc thr", 2'b10, oc_threshold_low_o)
        // Channel one sensing live, so a shutdown would show
        @(posedge clk_i) chan_on_i <= 2'b10;
        wait_valid();
        @(posedge clk_i) temp_hot_i <= 1;
        tick(5); `CHK("prewarn", 1'b1, temp_prewarning_flag_o)
        `CHK("no shutoff", 1'b1, sense_enable_o)
        apb(0, FAULT_REPORT_OFF, 0); tick(2); `CHK("hot read", 1'b1, temp_prewarning_flag_o)
        @(posedge clk_i) temp_hot_i <= 0;
        tick(5); `CHK("cool kept", 1'b1, temp_prewarning_flag_o)
        apb(0, FAULT_REPORT_OFF, 0); `CHK("fault rd", 32'h100, rd_data)
        tick(2); `CHK("cleared", 1'b0, temp_prewarning_flag_o)
        @(posedge clk_i) normal_mode_i <= 0;
        temp_hot_i <= 1;
        tick(5); `CHK("mode warn", 1'b0, temp_prewarning_flag_o)
        @(posedge clk_i) temp_hot_i <= 0;
        tick(4);
        @(posedge clk_i) normal_mode_i <= 1;
        // Pin disagrees with the on command: status follows the pin
        @(posedge clk_i) out_above_half_i <= 2'b01;
        tick(4); apb(0, STATUS_REPORT_OFF, 0); `CHK("status", 32'h1, rd_data)
        apb(0, 8'h20, 0); `CHK("unmapped err", 1'b1, rd_err)
        `CHK("unmapped data", 32'h0, rd_data)
        print_verdict();
    end
endmodule // lcts_sense_ctrl_tb_top
